// file: inc/ppm_defs.vh
// Constants for the power protection monitor
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH

// ==========================================
// Register offsets
`define PPM_REG_CTRL 4'h0
`define PPM_REG_CUR_LIM 4'h1
`define PPM_REG_PWR_LIM 4'h2
`define PPM_REG_VLT_LIM 4'h3
`define PPM_REG_CUR_DLY 4'h4
`define PPM_REG_PWR_DLY 4'h5
`define PPM_REG_VLT_DLY 4'h6
`define PPM_REG_WARMUP 4'h7
`define PPM_REG_STATUS 4'h8
`define PPM_REG_METER_V 4'h9
`define PPM_REG_METER_I 4'ha
`define PPM_REG_CMD 4'hb

// ==========================================
// Control register fields
`define PPM_CTRL_OC_EN 0
`define PPM_CTRL_OP_EN 1
`define PPM_CTRL_UV_EN 2
`define PPM_CTRL_BEEP 3
`define PPM_CTRL_RESET 16'h0008

// Command register fields (write one to act)
`define PPM_CMD_CLEAR 0
`define PPM_CMD_OUT_ON 1

// Status fields
`define PPM_ST_PROT 0
`define PPM_ST_OC 1
`define PPM_ST_OP 2
`define PPM_ST_UV 3
`define PPM_ST_OUT 4
`define PPM_ST_WARM 5

// Protection type codes
`define PPM_TYPE_NONE 2'h0
`define PPM_TYPE_OC 2'h1
`define PPM_TYPE_OP 2'h2
`define PPM_TYPE_UV 2'h3

`endif

// file: verilog/ppm_top.v
// Power protection monitor: limit checks, delay qualify, latch, clear
//
// How it works
// (R1) Current above limit longer than delay, when enabled, latches overcurrent protection.
// (R2) Power above limit longer than delay, when enabled, latches overpower protection.
// (R3) Voltage below limit after warm-up and delay, when enabled, latches undervoltage.
// (R4) Undervoltage checks are suppressed during the warm-up interval.
// (R5) Violations that vanish before the delay ends are ignored.
// (R6) Each function has its own enable; disabled functions never trip.
// (R7) Trip turns output off, lights indicators, beeps only if beep is on.
// (R8) While protected, report trip type and latest metered voltage and current.
// (R9) Protection stays latched until an explicit clear.
// (R10) A pulse on the rear clear input clears the latch.
// (R11) Escape or enter key clears the latch.
// (R12) Remote clear command clears the latch.
// (R13) Clearing leaves output off until on/off key or output-on command.
// (R14) Current limit is signed magnitude, applied to sourced and sunk current.
// (R15) Power limit is signed magnitude, applied to sourced and sunk power.
// (R16) Each function has its own delay counter, zeroed when violation ends.
// (R17) Warm-up counts from output switch-on; undervoltage masked until done.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "ppm_defs.vh"

module ppm_top #(
  parameter DW = 16,
  parameter CW = 16
) (
  input wire clk,
  input wire arst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire signed [DW-1:0] meter_v,
  input wire signed [DW-1:0] meter_i,
  input wire signed [DW-1:0] meter_p,
  input wire fault_clear_input,
  input wire key_esc,
  input wire key_enter,
  input wire key_onoff,
  output reg output_on,
  output reg protection_indicator,
  output reg output_off_indicator,
  output reg buzzer,
  output reg [1:0] prot_type,
  output reg [DW-1:0] rep_v,
  output reg [DW-1:0] rep_i
);

  // ==========================================
  // Helpers
  // Magnitude of a signed value; most negative saturates one short
  function [DW-1:0] mag;
    input [DW-1:0] x;
    begin
      if (x[DW-1])
        mag = (x == {1'b1, {(DW-1){1'b0}}}) ? {1'b0, {(DW-1){1'b1}}} : (~x + 1'b1);
      else
        mag = x;
    end
  endfunction

  // Magnitude compare shared by the two bidirectional limits
  function over_lim;
    input [DW-1:0] x;
    input [DW-1:0] thr;
    begin
      over_lim = (mag(x) > thr);
    end
  endfunction

  // ==========================================
  // Trip type and status encoders
  // Priority when several qualify together: current, power, voltage
  function [1:0] pick_type;
    input [2:0] q;
    begin
      if (q[0])
        pick_type = `PPM_TYPE_OC;
      else if (q[1])
        pick_type = `PPM_TYPE_OP;
      else if (q[2])
        pick_type = `PPM_TYPE_UV;
      else
        pick_type = `PPM_TYPE_NONE;
    end
  endfunction

  // Status word layout; type flags are decoded from the latched code
  function [15:0] status_word;
    input prot;
    input [1:0] typ;
    input out_on;
    input warm;
    begin
      status_word = 16'h0000;
      status_word[`PPM_ST_PROT] = prot;
      status_word[`PPM_ST_OC] = (typ == `PPM_TYPE_OC);
      status_word[`PPM_ST_OP] = (typ == `PPM_TYPE_OP);
      status_word[`PPM_ST_UV] = (typ == `PPM_TYPE_UV);
      status_word[`PPM_ST_OUT] = out_on;
      status_word[`PPM_ST_WARM] = warm;
    end
  endfunction

  // ==========================================
  // Configuration registers
  reg [15:0] ctrl;
  reg [DW-1:0] cur_lim;
  reg [DW-1:0] pwr_lim;
  reg [DW-1:0] vlt_lim;
  reg [CW-1:0] cur_dly;
  reg [CW-1:0] pwr_dly;
  reg [CW-1:0] vlt_dly;
  reg [CW-1:0] warm_len;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `PPM_CTRL_RESET;
      cur_lim <= {DW{1'b0}};
      pwr_lim <= {DW{1'b0}};
      vlt_lim <= {DW{1'b0}};
      cur_dly <= {CW{1'b0}};
      pwr_dly <= {CW{1'b0}};
      vlt_dly <= {CW{1'b0}};
      warm_len <= {CW{1'b0}};
    end else if (reg_wr) begin
      // Writes to read-only or unmapped indices are dropped
      case (reg_addr)
        `PPM_REG_CTRL: ctrl <= reg_wdata;
        `PPM_REG_CUR_LIM: cur_lim <= reg_wdata[DW-1:0];
        `PPM_REG_PWR_LIM: pwr_lim <= reg_wdata[DW-1:0];
        `PPM_REG_VLT_LIM: vlt_lim <= reg_wdata[DW-1:0];
        `PPM_REG_CUR_DLY: cur_dly <= reg_wdata[CW-1:0];
        `PPM_REG_PWR_DLY: pwr_dly <= reg_wdata[CW-1:0];
        `PPM_REG_VLT_DLY: vlt_dly <= reg_wdata[CW-1:0];
        `PPM_REG_WARMUP: warm_len <= reg_wdata[CW-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  wire cmd_wr = reg_wr && (reg_addr == `PPM_REG_CMD);
  wire cmd_clear = cmd_wr && reg_wdata[`PPM_CMD_CLEAR];
  wire cmd_on = cmd_wr && reg_wdata[`PPM_CMD_OUT_ON];

  // ==========================================
  // Clear sources
  // Rear input acts on its rising edge so a held level clears only once
  reg clr_in_d;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      clr_in_d <= 1'b0;
    else
      clr_in_d <= fault_clear_input;
  end
  wire clr_pulse = fault_clear_input && !clr_in_d; // R10
  // Keys act on level; a held key cannot hide a fault that still qualifies
  wire any_clear = clr_pulse || key_esc || key_enter || cmd_clear; // R10 R11 R12

  // ==========================================
  // Limit comparisons
  wire [DW-1:0] cur_thr = mag(cur_lim); // R14
  wire [DW-1:0] pwr_thr = mag(pwr_lim); // R15
  wire viol_oc = ctrl[`PPM_CTRL_OC_EN] && over_lim(meter_i, cur_thr); // R1 R6 R14
  wire viol_op = ctrl[`PPM_CTRL_OP_EN] && over_lim(meter_p, pwr_thr); // R2 R6 R15
  wire warm_done;
  wire viol_uv = ctrl[`PPM_CTRL_UV_EN] && warm_done && output_on &&
                 ($signed(meter_v) < $signed(vlt_lim)); // R3 R4 R6

  // ==========================================
  // Delay counters, one per function
  // Separate counters keep a spike on one input from shortening another's delay
  localparam NF = 3;
  wire [NF-1:0] viol = {viol_uv, viol_op, viol_oc};
  wire [NF*CW-1:0] dly_all = {vlt_dly, pwr_dly, cur_dly};
  wire [NF-1:0] qual;
  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_dly
      reg [CW-1:0] cnt;
      wire [CW-1:0] lim = dly_all[g*CW +: CW];
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
          cnt <= {CW{1'b0}};
        else if (!viol[g])
          cnt <= {CW{1'b0}}; // R5 R16
        else if (cnt != {CW{1'b1}})
          cnt <= cnt + 1'b1; // R16
      end
      // Trips only once the count reaches the delay with violation held
      assign qual[g] = viol[g] && (cnt >= lim); // R1 R2 R3 R5
    end
  endgenerate

  // ==========================================
  // Warm-up timer, restarted each time the output turns on
  // The count holds at the limit; only warm_ok is read onward
  reg [CW-1:0] warm_cnt;
  reg warm_ok;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warm_cnt <= {CW{1'b0}};
      warm_ok <= 1'b0;
    end else if (!output_on) begin
      warm_cnt <= {CW{1'b0}}; // R17
      warm_ok <= 1'b0;
    end else if (warm_cnt >= warm_len) begin
      warm_ok <= 1'b1; // R4 R17
    end else begin
      warm_cnt <= warm_cnt + 1'b1; // R17
    end
  end
  assign warm_done = warm_ok;

  // ==========================================
  // Protection state: one-hot
  localparam ST_RUN = 2'b01;
  localparam ST_PROT = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] next_type;
  wire trip = |qual;

  always @* begin
    next_state = state;
    next_type = prot_type;
    case (state)
      ST_RUN: begin
        if (trip) begin
          next_state = ST_PROT; // R1 R2 R3
          next_type = pick_type(qual); // R8
        end
      end
      ST_PROT: begin
        // Cause going away does not release the latch, and a fault that
        // still qualifies outweighs a clear in the same cycle
        if (any_clear && !trip) begin
          next_state = ST_RUN; // R9 R10 R11 R12
          next_type = `PPM_TYPE_NONE;
        end
      end
      default: begin
        next_state = ST_RUN;
        next_type = `PPM_TYPE_NONE;
      end
    endcase
  end

  wire in_prot_next = (next_state == ST_PROT);
  // An on request in the trip cycle is dropped, not held over
  wire turn_on = (key_onoff || cmd_on) && !in_prot_next; // R13

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RUN;
      prot_type <= `PPM_TYPE_NONE;
      output_on <= 1'b0;
      protection_indicator <= 1'b0;
      output_off_indicator <= 1'b1;
      buzzer <= 1'b0;
      rep_v <= {DW{1'b0}};
      rep_i <= {DW{1'b0}};
    end else begin
      state <= next_state;
      prot_type <= next_type; // R8
      protection_indicator <= in_prot_next; // R7 R9
      buzzer <= in_prot_next && ctrl[`PPM_CTRL_BEEP]; // R7
      // Clear never turns the output back on by itself
      if (in_prot_next) begin
        output_on <= 1'b0; // R7
        output_off_indicator <= 1'b1; // R7
      end else if (turn_on) begin
        output_on <= 1'b1; // R13
        output_off_indicator <= 1'b0;
      end
      if (in_prot_next) begin
        rep_v <= meter_v; // R8
        rep_i <= meter_i; // R8
      end
    end
  end

  // ==========================================
  // Read port; data valid the cycle after the strobe
  wire [15:0] status_now = status_word(state == ST_PROT, prot_type, output_on, warm_ok); // R8
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `PPM_REG_CTRL: reg_rdata <= ctrl;
        `PPM_REG_CUR_LIM: reg_rdata <= {{(16-DW){1'b0}}, cur_lim};
        `PPM_REG_PWR_LIM: reg_rdata <= {{(16-DW){1'b0}}, pwr_lim};
        `PPM_REG_VLT_LIM: reg_rdata <= {{(16-DW){1'b0}}, vlt_lim};
        `PPM_REG_CUR_DLY: reg_rdata <= {{(16-CW){1'b0}}, cur_dly};
        `PPM_REG_PWR_DLY: reg_rdata <= {{(16-CW){1'b0}}, pwr_dly};
        `PPM_REG_VLT_DLY: reg_rdata <= {{(16-CW){1'b0}}, vlt_dly};
        `PPM_REG_WARMUP: reg_rdata <= {{(16-CW){1'b0}}, warm_len};
        `PPM_REG_STATUS: reg_rdata <= status_now; // R8
        `PPM_REG_METER_V: reg_rdata <= {{(16-DW){1'b0}}, rep_v};
        `PPM_REG_METER_I: reg_rdata <= {{(16-DW){1'b0}}, rep_i};
        default: reg_rdata <= 16'h0000;
      endcase
    end else
      reg_rdata <= 16'h0000;
  end

endmodule // ppm_top

// file: dv/ppm_top_asserts.sv
// Port assertions for the power protection monitor
`timescale 1ns/10ps
module ppm_top_asserts #(parameter DW = 16) (
  input wire clk,
  input wire arst_n,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire key_esc,
  input wire key_enter,
  input wire key_onoff,
  input wire fault_clear_input,
  input wire signed [DW-1:0] meter_v,
  input wire output_on,
  input wire protection_indicator,
  input wire output_off_indicator,
  input wire buzzer,
  input wire [1:0] prot_type,
  input wire [DW-1:0] rep_v
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire cmd_wr = reg_wr && reg_addr == 4'hb;
  wire any_clr = key_esc || key_enter || fault_clear_input || (cmd_wr && reg_wdata[0]);
  // ==========================================
  // Protection state
  a_trip_output_off: assert property ($rose(protection_indicator) |->
    !output_on && output_off_indicator) else $error("output left on at trip");
  a_off_ind_match: assert property (output_off_indicator == !output_on)
    else $error("off indicator wrong");
  a_buzz_needs_prot: assert property (buzzer |-> protection_indicator)
    else $error("buzzer without protection");
  a_type_while_prot: assert property (protection_indicator |-> prot_type != 2'h0)
    else $error("no trip type while protected");
  a_rep_tracks_v: assert property (protection_indicator && $past(protection_indicator) |->
    rep_v == $past(meter_v)) else $error("reported voltage stale");
  a_prot_holds: assert property (protection_indicator && !any_clr |=>
    protection_indicator) else $error("protection dropped without clear");
  a_clear_drops_all: assert property ($fell(protection_indicator) |->
    prot_type == 2'h0 && !buzzer) else $error("clear left indication");
  a_clear_stays_off: assert property ($fell(protection_indicator) &&
    !$past(key_onoff || (cmd_wr && reg_wdata[1])) |-> !output_on)
    else $error("output back on at clear");
  a_on_needs_cause: assert property ($rose(output_on) |->
    $past(key_onoff || (cmd_wr && reg_wdata[1]))) else $error("output on without request");
  cover property ($rose(protection_indicator));
  cover property ($fell(protection_indicator));
  cover property ($rose(buzzer));
endmodule // ppm_top_asserts

bind ppm_top ppm_top_asserts #(.DW(DW)) ppm_top_asserts_i (.*);

// file: dv/ppm_meter_model.sv
// Metering front end model driving the monitored levels
`timescale 1ns/10ps
module ppm_meter_model (
  input wire clk,
  input wire [15:0] set_v,
  input wire [15:0] set_i,
  input wire [15:0] set_p,
  output reg signed [15:0] meter_v,
  output reg signed [15:0] meter_i,
  output reg signed [15:0] meter_p
);
  // One conversion cycle of latency; pulse widths are kept exact
  always @(posedge clk) begin
    meter_v <= set_v;
    meter_i <= set_i;
    meter_p <= set_p;
  end
endmodule // ppm_meter_model

// file: dv/tb_power_protection_monitor.sv
// Self-checking bench for the power protection monitor
`timescale 1ns/10ps
module tb_power_protection_monitor;
  reg clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  reg fault_clear_input = 1'b0, key_esc = 1'b0, key_enter = 1'b0, key_onoff = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000, mv = 16'h0050, mi = 16'h0000, mp = 16'h0000;
  reg [31:0] seed = 32'h1cfcc7f6;
  reg [31:0] q[$];
  integer n_fail = 0, compares = 0, f, k;
  wire [15:0] reg_rdata, rep_v, rep_i, meter_v, meter_i, meter_p;
  wire output_on, protection_indicator, output_off_indicator, buzzer;
  wire [1:0] prot_type;
  ppm_meter_model ppm_meter_model_i (.clk(clk), .set_v(mv), .set_i(mi), .set_p(mp),
    .meter_v(meter_v), .meter_i(meter_i), .meter_p(meter_p));
  ppm_top ppm_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meter_v(meter_v), .meter_i(meter_i), .meter_p(meter_p),
    .fault_clear_input(fault_clear_input), .key_esc(key_esc), .key_enter(key_enter),
    .key_onoff(key_onoff), .output_on(output_on), .protection_indicator(protection_indicator),
    .output_off_indicator(output_off_indicator), .buzzer(buzzer), .prot_type(prot_type),
    .rep_v(rep_v), .rep_i(rep_i));
  initial forever #50 clk = ~clk;
  // ==========================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  // Current and power limits are written negative so the signed limit path is exercised
  function [15:0] cfg(input integer k);
    cfg = k == 1 ? 16'hff9c : k == 2 ? 16'hff38 : k == 3 ? 16'h0032 :
          k == 7 ? 16'h0014 : 16'h0003;
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // A spare edge after each strobe keeps one assignment per signal per step
  task wr(input [3:0] a, input [15:0] d);
    begin
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
    end
  endtask
  task rd(input [3:0] a, input [15:0] m, input [15:0] e);
    begin
      reg_rd <= 1'b1;
      reg_addr <= a;
      q.push_back({m, e});
      tick(1);
      reg_rd <= 1'b0;
      tick(1);
    end
  endtask
  task normal;
    begin
      seed = xs(seed);
      mv <= 16'h0050;
      mi <= seed[15:0] % 16'd199 - 16'd99;
      mp <= seed[31:16] % 16'd399 - 16'd199;
    end
  endtask
  // Sunk current and power test the magnitude compare
  task viol(input integer c);
    case (c)
      0: mi <= 16'hff6a;
      1: mp <= 16'hff06;
      default: mv <= 16'h000a;
    endcase
  endtask
  task clr(input integer c);
    begin
      case (c)
        0: key_esc <= 1'b1;
        1: fault_clear_input <= 1'b1;
        2: wr(4'hb, 16'h0001);
        default: key_enter <= 1'b1;
      endcase
      tick(1);
      key_esc <= 1'b0;
      key_enter <= 1'b0;
      fault_clear_input <= 1'b0;
      tick(1);
    end
  endtask
  task turn_on;
    begin
      key_onoff <= 1'b1;
      tick(1);
      key_onoff <= 1'b0;
      tick(1);
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      chk(reg_rdata & q[0][31:16], q[0][15:0]);
      q.delete(0);
    end
    rd_d <= reg_rd;
  end
  // ==========================================
  // Sequence; the warm-up bit is masked only where its timing is not the point
  initial begin
    tick(6);
    arst_n <= 1'b1;
    tick(1);
    rd(4'h8, 16'hffdf, 16'h0000);
    rd(4'h0, 16'hffff, 16'h0008);
    rd(4'hc, 16'hffff, 16'h0000);
    for (k = 1; k < 8; k = k + 1)
      wr(k[3:0], cfg(k));
    for (k = 1; k < 8; k = k + 1)
      rd(k[3:0], 16'hffff, cfg(k));
    wr(4'h0, 16'h0004);
    turn_on;
    viol(2);
    tick(8);
    normal;
    tick(3);
    rd(4'h8, 16'hffff, 16'h0010);
    wr(4'h0, 16'h0000);
    viol(0);
    viol(1);
    viol(2);
    tick(30);
    normal;
    tick(3);
    rd(4'h8, 16'hffff, 16'h0030);
    $display("test setup done");
    for (f = 0; f < 4; f = f + 1) begin
      wr(4'h0, f < 2 ? 16'h000f : 16'h0007);
      tick(25);
      viol(f % 3);
      tick(3);
      normal;
      tick(3);
      rd(4'h8, 16'hffdf, 16'h0010);
      viol(f % 3);
      tick(7);
      rd(4'h8, 16'hffdf, 16'h0001 | (16'h0002 << (f % 3)));
      chk({14'h0, prot_type}, f % 3 + 1);
      chk({15'h0, buzzer}, f < 2);
      chk({13'h0, protection_indicator, output_off_indicator, output_on}, 16'h0006);
      chk(rep_v, mv);
      chk(rep_i, mi);
      rd(4'h9, 16'hffff, mv);
      rd(4'ha, 16'hffff, mi);
      normal;
      tick(10);
      rd(4'h8, 16'hffdf, 16'h0001 | (16'h0002 << (f % 3)));
      clr(f);
      chk({13'h0, protection_indicator, output_off_indicator, output_on}, 16'h0002);
      rd(4'h8, 16'hffdf, 16'h0000);
      if (f[0]) wr(4'hb, 16'h0002);
      else turn_on;
      rd(4'h8, 16'hffdf, 16'h0010);
      chk({13'h0, protection_indicator, output_off_indicator, output_on}, 16'h0001);
      $display("test %0d done", f);
    end
    report_and_stop;
  end
  // Guard against a hung run
  initial begin
    #5000000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule // tb_power_protection_monitor
